// ### bench/cdd_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// Downstream receiver: times the rising edges of each P leg in system cycles
module cdd_rx_model (
  input  wire logic             i_clk,
  input  wire logic [3:0]       i_p,
  output logic      [3:0][15:0] o_per,
  output logic      [3:0][15:0] o_rise
);
  logic [15:0] cnt_r = 16'h0000;
  logic [3:0]  p_r;
  always @(posedge i_clk) begin
    cnt_r <= cnt_r + 16'h0001;
    p_r   <= i_p;
    for (int i = 0; i < 4; i++) begin
      if (i_p[i] && !p_r[i]) begin
        o_per[i]  <= cnt_r - o_rise[i];
        o_rise[i] <= cnt_r;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/cdd_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module cdd_top_props (
  input wire logic        I_CLK_SYS,
  input wire logic        I_NRST,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic [31:0] I_WB_ADR,
  input wire logic [3:0]  I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic        O_WB_ACK,
  input wire logic [31:0] O_WB_DAT,
  input wire logic [3:0]  O_DRV_P,
  input wire logic [3:0]  O_DRV_N,
  input wire logic [3:0]  O_DRV_P_OE,
  input wire logic [3:0]  O_DRV_N_OE,
  input wire logic [3:0]  O_DRV_HSTL,
  input wire logic [3:0]  O_DRV_LVDS,
  input wire logic [3:0]  O_DRV_BOOST,
  input wire logic        O_SYNC
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  logic       req;
  logic [3:0] dif;
  assign req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  // Differential formats drive the leg pair as a complementary couple
  assign dif = O_DRV_HSTL | O_DRV_LVDS;
  chk_ack_after_req: assert property (req |=> O_WB_ACK)
    else $error("no ack one cycle after a request");
  chk_ack_one_cycle: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  chk_rd_upper_zero: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == '0)
    else $error("read data above bit 7 not zero");
  chk_rd_data_hold: assert property (!O_WB_ACK |-> $stable(O_WB_DAT))
    else $error("read data changed without ack");
  chk_bad_adr_zero: assert property (req && !I_WB_WE && I_WB_ADR[1:0] != 2'h0 |=> O_WB_DAT == 32'h0000_0000)
    else $error("misaligned read not zero");
  chk_fmt_exclusive: assert property ((O_DRV_HSTL & O_DRV_LVDS) == 4'h0)
    else $error("driver in two formats at once");
  chk_diff_both_legs: assert property ((dif & ~(O_DRV_P_OE & O_DRV_N_OE)) == 4'h0)
    else $error("differential driver with a leg off");
  chk_diff_legs_inv: assert property ((dif & ~(O_DRV_P ^ O_DRV_N)) == 4'h0)
    else $error("differential legs not complementary");
  chk_boost_lvds: assert property ((O_DRV_BOOST & ~O_DRV_LVDS) == 4'h0)
    else $error("boost outside LVDS");
  chk_sync_single: assert property (O_SYNC |=> !O_SYNC)
    else $error("sync pulse longer than one cycle");
  chk_manual_sync: assert property (req && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == 32'h0000_1480 && I_WB_DAT[2]
    |=> O_SYNC)
    else $error("manual sync write gave no sync");
  cover property (O_SYNC);
  cover property (|O_DRV_BOOST);
  cover property (req && !I_WB_WE ##1 O_WB_ACK);
endmodule
bind cdd_top cdd_top_props u_props (.I_CLK_SYS, .I_NRST, .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR, .I_WB_SEL,
  .I_WB_DAT, .O_WB_ACK, .O_WB_DAT, .O_DRV_P, .O_DRV_N, .O_DRV_P_OE, .O_DRV_N_OE, .O_DRV_HSTL, .O_DRV_LVDS,
  .O_DRV_BOOST, .O_SYNC);
`default_nettype wire

// ### bench/tb_clock_distribution_dividers.sv
`timescale 1ns/1ps
`default_nettype none
module tb_clock_distribution_dividers;
  typedef struct packed {logic [12:0] a; logic [7:0] rst, wv, rv;} cdd_row_t;
  logic             clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic             p1 = 1'b0, p2 = 1'b0, fl = 1'b0, pl = 1'b0, ack, sync;
  logic      [31:0] adr = 32'h0000_0000, wdat = 32'h0000_0000, rdat, rd;
  logic      [3:0]  sel = 4'h0, dp, dn, poe, noe, hstl, lvds, bst;
  logic [3:0][15:0] per, rise;
  logic      [2:0]  c1 = 3'h0, c2 = 3'h0;
  int               num_errors = 0, n_checks = 0, n_cyc = 0, k;
  cdd_row_t rows [15] = '{'{13'h1408, 8'h00, 8'h11, 8'h11}, '{13'h1409, 8'h00, 8'hEE, 8'h00},
    '{13'h140C, 8'h00, 8'hFF, 8'h0F}, '{13'h1410, 8'h00, 8'hFF, 8'h3F}, '{13'h1414, 8'h10, 8'hFF, 8'h7F},
    '{13'h1418, 8'h10, 8'hAA, 8'h2A}, '{13'h141C, 8'h00, 8'h22, 8'h22}, '{13'h1420, 8'h00, 8'hF5, 8'h05},
    '{13'h1424, 8'h00, 8'hC7, 8'h07}, '{13'h1428, 8'h10, 8'h55, 8'h55}, '{13'h142C, 8'h10, 8'h33, 8'h33},
    '{13'h1430, 8'h00, 8'h44, 8'h44}, '{13'h1434, 8'h00, 8'hFA, 8'h0A}, '{13'h1438, 8'h00, 8'hE9, 8'h29},
    '{13'h0000, 8'h00, 8'h5A, 8'h00}};
  logic [4:0]  fmt_exp [8] = '{5'h00, 5'h1C, 5'h1B, 5'h00, 5'h18, 5'h10, 5'h08, 5'h00};
  logic [1:0]  pol_exp [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  logic [9:0]  rat [5]     = '{10'h000, 10'h002, 10'h002, 10'h101, 10'h3FF};
  logic [15:0] rat_per [5] = '{16'h0008, 16'h0018, 16'h0024, 16'h0810, 16'h2000};
  logic [12:0] su_a [11]   = '{13'h1408, 13'h140C, 13'h1410, 13'h141C, 13'h1420, 13'h1424, 13'h1430, 13'h1434,
    13'h1438, 13'h1418, 13'h1428};
  logic [7:0]  su_d [11]   = '{8'h03, 8'h00, 8'h00, 8'h03, 8'h00, 8'h02, 8'h03, 8'h00, 8'h00, 8'h11, 8'h11};
  // Lock table: mode, freq pin, phase pin, sync pulses expected
  logic [4:0]  lk [6]      = '{5'b10011, 5'b01101, 5'b00110, 5'b11110, 5'b10100, 5'b01010};

  cdd_top DUT (.I_CLK_SYS(clk), .I_NRST(nrst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_ACK(ack), .O_WB_DAT(rdat), .I_PRESC1(p1), .I_PRESC2(p2),
    .I_FREQ_LOCK(fl), .I_PHASE_LOCK(pl), .O_DRV_P(dp), .O_DRV_N(dn), .O_DRV_P_OE(poe), .O_DRV_N_OE(noe),
    .O_DRV_HSTL(hstl), .O_DRV_LVDS(lvds), .O_DRV_BOOST(bst), .O_SYNC(sync));
  cdd_rx_model u_rx (.i_clk(clk), .i_p(dp), .o_per(per), .o_rise(rise));

  always #2 clk = ~clk;
  // Prescalers: half periods of 4 and 6 system cycles
  always @(posedge clk) begin
    c1 <= (c1 == 3'h3) ? 3'h0 : c1 + 3'h1;
    c2 <= (c2 == 3'h5) ? 3'h0 : c2 + 3'h1;
    if (c1 == 3'h3) p1 <= ~p1;
    if (c2 == 3'h5) p2 <= ~p2;
    n_cyc <= n_cyc + 1;
    if (n_cyc == 60000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, 19'h0, a, 4'h1, 24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    {cyc, stb} <= 2'h0;
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      wb(1'b0, rows[i].a, 8'h00);
      chk(rd, 32'(rows[i].rst));
    end
    foreach (rows[i]) wb(1'b1, rows[i].a, rows[i].wv);
    foreach (rows[i]) begin
      wb(1'b0, rows[i].a, 8'h00);
      chk(rd, 32'(rows[i].rv));
    end
    // Channel held down so the legs show static levels
    wb(1'b1, 13'h140C, 8'h08);
    for (int f = 0; f < 8; f++) begin
      wb(1'b1, 13'h1414, {1'b0, 3'(f), 4'h3});
      repeat (4) @(posedge clk);
      chk(32'({poe[0], noe[0], hstl[0], lvds[0], bst[0]}), 32'(fmt_exp[f]));
    end
    wb(1'b1, 13'h1414, 8'h22);
    repeat (4) @(posedge clk);
    chk(32'({poe[0], noe[0], lvds[0]}), 32'h0000_0000);
    for (int p = 0; p < 4; p++) begin
      wb(1'b1, 13'h1414, {4'h4, 2'(p), 2'h1});
      repeat (4) @(posedge clk);
      chk(32'({dp[0], dn[0]}), 32'(pol_exp[p]));
    end
    wb(1'b1, 13'h1414, 8'h1D);
    repeat (4) @(posedge clk);
    chk(32'({dp[0], dn[0]}), 32'h0000_0001);
    wb(1'b1, 13'h1414, 8'h11);
    for (int r = 0; r < 5; r++) begin
      wb(1'b1, 13'h1408, rat[r][7:0]);
      wb(1'b1, 13'h140C, {5'h0, r == 2, rat[r][9:8]});
      repeat (3 * rat_per[r] + 20) @(posedge clk);
      chk(32'(per[0]), 32'(rat_per[r]));
    end
    foreach (su_a[i]) wb(1'b1, su_a[i], su_d[i]);
    wb(1'b1, 13'h1480, 8'h06);
    repeat (40) @(posedge clk);
    @(posedge dp[1]);
    repeat (2) @(posedge clk);
    chk(32'(rise[1] - rise[0]), 32'h0000_0008);
    chk(32'(rise[2]), 32'(rise[0]));
    foreach (lk[i]) begin
      wb(1'b1, 13'h1480, {6'h0, lk[i][4:3]});
      k = 0;
      {fl, pl} <= lk[i][2:1];
      repeat (12) begin
        @(posedge clk);
        if (sync === 1'b1) k++;
      end
      chk(32'(k), 32'(lk[i][0]));
      // Status shows the synchronised lock levels while the pins are still held
      wb(1'b0, 13'h1484, 8'h00);
      chk(32'(rd[1:0]), 32'({lk[i][1], lk[i][2]}));
      {fl, pl} <= 2'h0;
      repeat (12) @(posedge clk);
    end
    // Reset in mid-run must bring every register back
    wb(1'b1, 13'h140C, 8'h0C);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({ack, sync, poe, hstl}), 32'h0000_0000);
    nrst <= 1'b1;
    wb(1'b0, 13'h140C, 8'h00);
    chk(rd, 32'h0000_0000);
    wb(1'b0, 13'h1414, 8'h00);
    chk(rd, 32'h0000_0010);
    wb(1'b0, 13'h1480, 8'h00);
    chk(rd, 32'h0000_0002);
    print_verdict();
  end
endmodule
`default_nettype wire

// ### hw/cdd_chdiv.sv
`timescale 1ns/1ps
`default_nettype none
module cdd_chdiv
  import cdd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  cdd_div_if.div   d
);

  typedef struct packed {
    logic [9:0] cnt;
    logic [5:0] dly;
    logic       clk;
  } cdd_div_st_t;

  cdd_div_st_t st_r;
  cdd_div_st_t st_nxt;
  logic        half_edge;

  // Each prescaler edge marks one half period of the divider input
  assign half_edge = d.presc_sel ? d.presc_edge[1] : d.presc_edge[0];

  always_comb begin
    st_nxt = st_r;
    if (d.pd) begin
      st_nxt = '0;
    end else if (d.sync) begin
      st_nxt.cnt = '0;
      st_nxt.clk = 1'b0;
      st_nxt.dly = d.phase;
    end else if (half_edge) begin
      if (st_r.dly != '0) begin
        st_nxt.dly = st_r.dly - 6'h01;
      end else if (st_r.cnt == d.ratio) begin
        st_nxt.cnt = '0;
        st_nxt.clk = ~st_r.clk;
      end else begin
        st_nxt.cnt = st_r.cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign d.clk_out = st_r.clk;

endmodule
`default_nettype wire

// ### hw/cdd_div_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cdd_div_if;
  logic [9:0] ratio;
  logic       pd;
  logic       presc_sel;
  logic [5:0] phase;
  logic       sync;
  logic [1:0] presc_edge;
  logic       clk_out;

  modport ctl (output ratio, output pd, output presc_sel, output phase, output sync,
               output presc_edge, input clk_out);
  modport div (input ratio, input pd, input presc_sel, input phase, input sync,
               input presc_edge, output clk_out);
endinterface
`default_nettype wire

// ### hw/cdd_pkg.sv
package cdd_pkg;

  // Geometry
  localparam int unsigned CDD_NCH   = 3;
  localparam int unsigned CDD_NDRV  = 4;
  localparam int unsigned CDD_NREG  = 13;
  localparam int unsigned CDD_DIV_W = 10;
  localparam int unsigned CDD_PH_W  = 6;

  // Register indices; byte address on the bus is four times the index
  localparam logic [10:0] CDD_IDX_BASE    = 11'h502;
  localparam logic [10:0] CDD_IDX_CH0_LO  = 11'h502;
  localparam logic [10:0] CDD_IDX_CH0_CTL = 11'h503;
  localparam logic [10:0] CDD_IDX_CH0_PH  = 11'h504;
  localparam logic [10:0] CDD_IDX_DRV1    = 11'h505;
  localparam logic [10:0] CDD_IDX_DRV2    = 11'h506;
  localparam logic [10:0] CDD_IDX_CH1_LO  = 11'h507;
  localparam logic [10:0] CDD_IDX_CH1_CTL = 11'h508;
  localparam logic [10:0] CDD_IDX_CH1_PH  = 11'h509;
  localparam logic [10:0] CDD_IDX_DRV3    = 11'h50A;
  localparam logic [10:0] CDD_IDX_DRV4    = 11'h50B;
  localparam logic [10:0] CDD_IDX_CH2_LO  = 11'h50C;
  localparam logic [10:0] CDD_IDX_CH2_CTL = 11'h50D;
  localparam logic [10:0] CDD_IDX_CH2_PH  = 11'h50E;
  localparam logic [10:0] CDD_IDX_SYNC    = 11'h520;
  localparam logic [10:0] CDD_IDX_STAT    = 11'h521;

  // Slot of each register inside the storage array (slot = index - base)
  localparam int unsigned CDD_CH_SLOT  [CDD_NCH]  = '{0, 5, 10};
  localparam int unsigned CDD_DRV_SLOT [CDD_NDRV] = '{3, 4, 8, 9};
  // Channel that feeds each output driver
  localparam int unsigned CDD_DRV_CH   [CDD_NDRV] = '{0, 1, 2, 2};

  // Field positions
  localparam int unsigned CDD_CTL_HI_LSB  = 0;
  localparam int unsigned CDD_CTL_SEL_BIT = 2;
  localparam int unsigned CDD_CTL_PD_BIT  = 3;
  localparam int unsigned CDD_DRV_EN_BIT  = 0;
  localparam int unsigned CDD_DRV_BST_BIT = 1;
  localparam int unsigned CDD_DRV_POL_LSB = 2;
  localparam int unsigned CDD_DRV_FMT_LSB = 4;
  localparam int unsigned CDD_SYN_MOD_LSB = 0;
  localparam int unsigned CDD_SYN_MAN_BIT = 2;

  // Writable bit masks, everything else reads zero
  localparam logic [7:0] CDD_WM_LO  = 8'hFF;
  localparam logic [7:0] CDD_WM_CTL = 8'h0F;
  localparam logic [7:0] CDD_WM_PH  = 8'h3F;
  localparam logic [7:0] CDD_WM_DRV = 8'h7F;

  // Reset values
  localparam logic [7:0] CDD_RST_LO   = 8'h00;
  localparam logic [7:0] CDD_RST_CTL  = 8'h00;
  localparam logic [7:0] CDD_RST_PH   = 8'h00;
  localparam logic [7:0] CDD_RST_DRV  = 8'h10;
  localparam logic [1:0] CDD_RST_MODE = 2'h2;

  typedef enum logic [2:0] {
    CDD_FMT_PD     = 3'b000,
    CDD_FMT_HSTL   = 3'b001,
    CDD_FMT_LVDS   = 3'b010,
    CDD_FMT_CMOS   = 3'b100,
    CDD_FMT_CMOS_P = 3'b101,
    CDD_FMT_CMOS_N = 3'b110
  } cdd_fmt_t;

  typedef enum logic [1:0] {
    CDD_SM_MANUAL = 2'b00,
    CDD_SM_FREQ   = 2'b01,
    CDD_SM_PHASE  = 2'b10
  } cdd_smode_t;

endpackage

// ### hw/cdd_top.sv
// How it works
// - Each channel keeps a 10-bit divide value, low byte in its first register and top two bits in bits 1:0 of its second.
// - A channel divides its input clock by the divide value plus one, so zero passes it through and 1023 gives 1024.
// - Bit 3 of the second channel register powers the channel down when set and resets to zero.
// - Bit 2 of the second channel register picks the second prescaler when set and the first when clear, clear at reset.
// - After a sync each divider starts late by the 6-bit phase field in half input periods, zero meaning no offset.
// - The 3-bit format field picks off, HSTL (reset), LVDS, CMOS both legs, P leg only or N leg only; 011 and 111 are reserved.
// - In CMOS mode the 2-bit polarity field sets the legs to pos/neg, pos/pos, neg/pos or neg/neg, pos/neg at reset.
// - Bit 1 of a driver register boosts the LVDS drive level when set, normal at reset, and there is no CMOS drive choice.
// - A driver is enabled only while bit 0 of its register is set, and it is disabled at reset.
// - The second driver has its own register laid out like the first driver's.
// - The third and fourth drivers have registers laid out and behaving like the first driver's.
// - The second channel has three registers that behave like the first channel's.
// - The third channel has three registers that behave like the first channel's.
// - The automatic sync mode is manual only, frequency lock, phase lock (reset) or reserved.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cdd_top
  import cdd_pkg::*;
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_NRST,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [31:0] I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic             O_WB_ACK,
  output logic      [31:0] O_WB_DAT,
  input  wire logic        I_PRESC1,
  input  wire logic        I_PRESC2,
  input  wire logic        I_FREQ_LOCK,
  input  wire logic        I_PHASE_LOCK,
  output logic      [3:0]  O_DRV_P,
  output logic      [3:0]  O_DRV_N,
  output logic      [3:0]  O_DRV_P_OE,
  output logic      [3:0]  O_DRV_N_OE,
  output logic      [3:0]  O_DRV_HSTL,
  output logic      [3:0]  O_DRV_LVDS,
  output logic      [3:0]  O_DRV_BOOST,
  output logic             O_SYNC
);

  typedef struct packed {
    logic [CDD_NREG-1:0][7:0] regs;
    logic [1:0]               mode;
    logic                     ack;
    logic [31:0]              rdat;
    logic [1:0]               presc_s1;
    logic [1:0]               presc_s2;
    logic [1:0]               presc_s3;
    logic [1:0]               lock_s1;
    logic [1:0]               lock_s2;
    logic [1:0]               lock_s3;
    logic                     sync;
    logic [3:0]               p;
    logic [3:0]               n;
    logic [3:0]               poe;
    logic [3:0]               noe;
    logic [3:0]               hstl;
    logic [3:0]               lvds;
    logic [3:0]               boost;
  } cdd_top_st_t;

  cdd_top_st_t        st_r;
  cdd_top_st_t        st_nxt;
  logic [CDD_NCH-1:0] ch_clk;
  logic [10:0]        idx;
  logic               addr_ok;
  logic               hit;
  logic               wr;
  logic               man_sync;
  logic               auto_sync;
  logic               freq_rise;
  logic               phase_rise;

  cdd_div_if dif [CDD_NCH] ();

  // Storage slot for a register index; CDD_NREG means not a stored register
  function automatic logic [3:0] cdd_slot(input logic [10:0] i, input logic ok);
    logic [10:0] off;
    off = i - CDD_IDX_BASE;
    if (ok && i >= CDD_IDX_BASE && i <= CDD_IDX_CH2_PH) begin
      cdd_slot = off[3:0];
    end else begin
      cdd_slot = 4'(CDD_NREG);
    end
  endfunction

  // Writable bits of a slot; reserved bits stay zero
  function automatic logic [7:0] cdd_wmask(input logic [3:0] s);
    logic [7:0] m;
    m = CDD_WM_DRV;
    for (int c = 0; c < CDD_NCH; c++) begin
      if (s == 4'(CDD_CH_SLOT[c])) begin
        m = CDD_WM_LO;
      end else if (s == 4'(CDD_CH_SLOT[c] + 1)) begin
        m = CDD_WM_CTL;
      end else if (s == 4'(CDD_CH_SLOT[c] + 2)) begin
        m = CDD_WM_PH;
      end
    end
    cdd_wmask = m;
  endfunction

  function automatic logic [7:0] cdd_rstval(input int unsigned s);
    logic [7:0] v;
    v = CDD_RST_DRV;
    for (int c = 0; c < CDD_NCH; c++) begin
      if (s == CDD_CH_SLOT[c]) begin
        v = CDD_RST_LO;
      end else if (s == CDD_CH_SLOT[c] + 1) begin
        v = CDD_RST_CTL;
      end else if (s == CDD_CH_SLOT[c] + 2) begin
        v = CDD_RST_PH;
      end
    end
    cdd_rstval = v;
  endfunction

  assign idx     = I_WB_ADR[12:2];
  // Only word aligned addresses with nothing above the map decode
  assign addr_ok = (I_WB_ADR[31:13] == '0) && (I_WB_ADR[1:0] == 2'b00);
  assign hit     = I_WB_CYC && I_WB_STB && !st_r.ack;
  assign wr      = hit && I_WB_WE && I_WB_SEL[0];

  assign man_sync   = wr && addr_ok && (idx == CDD_IDX_SYNC) && I_WB_DAT[CDD_SYN_MAN_BIT];
  assign freq_rise  = st_r.lock_s2[0] && !st_r.lock_s3[0];
  assign phase_rise = st_r.lock_s2[1] && !st_r.lock_s3[1];

  always_comb begin
    case (cdd_smode_t'(st_r.mode))
      CDD_SM_FREQ:  auto_sync = freq_rise;
      CDD_SM_PHASE: auto_sync = phase_rise;
      default:      auto_sync = 1'b0;
    endcase
  end

  // Channel dividers, each fed from its own three registers
  for (genvar c = 0; c < CDD_NCH; c++) begin : g_ch
    localparam int unsigned S = CDD_CH_SLOT[c];
    assign dif[c].ratio      = {st_r.regs[S+1][CDD_CTL_HI_LSB +: 2], st_r.regs[S]};
    assign dif[c].pd         = st_r.regs[S+1][CDD_CTL_PD_BIT];
    assign dif[c].presc_sel  = st_r.regs[S+1][CDD_CTL_SEL_BIT];
    assign dif[c].phase      = st_r.regs[S+2][CDD_PH_W-1:0];
    assign dif[c].sync       = st_r.sync;
    assign dif[c].presc_edge = st_r.presc_s2 ^ st_r.presc_s3;
    assign ch_clk[c]         = dif[c].clk_out;

    cdd_chdiv u_div (
      .i_clk  (I_CLK_SYS),
      .i_nrst (I_NRST),
      .d      (dif[c])
    );
  end

  always_comb begin
    logic [3:0] slot;
    logic [7:0] m;
    logic [7:0] cfg;
    logic       clk;
    logic       en;
    logic [1:0] pol;
    slot = '0;
    m    = '0;
    cfg  = '0;
    clk  = 1'b0;
    en   = 1'b0;
    pol  = '0;
    st_nxt = st_r;

    // Pins from outside the clock domain pass two flops before use
    st_nxt.presc_s1 = {I_PRESC2, I_PRESC1};
    st_nxt.presc_s2 = st_r.presc_s1;
    st_nxt.presc_s3 = st_r.presc_s2;
    st_nxt.lock_s1  = {I_PHASE_LOCK, I_FREQ_LOCK};
    st_nxt.lock_s2  = st_r.lock_s1;
    st_nxt.lock_s3  = st_r.lock_s2;

    st_nxt.sync = man_sync || auto_sync;
    st_nxt.ack  = hit;

    slot = cdd_slot(idx, addr_ok);
    if (hit) begin
      if (slot < 4'(CDD_NREG)) begin
        st_nxt.rdat = {24'h00_0000, st_r.regs[slot]};
      end else if (addr_ok && idx == CDD_IDX_SYNC) begin
        st_nxt.rdat = {30'h0000_0000, st_r.mode};
      end else if (addr_ok && idx == CDD_IDX_STAT) begin
        st_nxt.rdat = {27'h000_0000, ch_clk, st_r.lock_s2};
      end else begin
        st_nxt.rdat = 32'h0000_0000;
      end
    end

    if (wr) begin
      if (slot < 4'(CDD_NREG)) begin
        m = cdd_wmask(slot);
        st_nxt.regs[slot] = (st_r.regs[slot] & ~m) | (I_WB_DAT[7:0] & m);
      end else if (addr_ok && idx == CDD_IDX_SYNC) begin
        st_nxt.mode = I_WB_DAT[CDD_SYN_MOD_LSB +: 2];
      end
    end

    // Output drivers; legs are registered so glitches in the decode never reach a pin
    for (int d = 0; d < CDD_NDRV; d++) begin
      cfg = st_r.regs[CDD_DRV_SLOT[d]];
      clk = ch_clk[CDD_DRV_CH[d]];
      en  = cfg[CDD_DRV_EN_BIT];
      pol = cfg[CDD_DRV_POL_LSB +: 2];
      st_nxt.p[d]     = 1'b0;
      st_nxt.n[d]     = 1'b0;
      st_nxt.poe[d]   = 1'b0;
      st_nxt.noe[d]   = 1'b0;
      st_nxt.hstl[d]  = 1'b0;
      st_nxt.lvds[d]  = 1'b0;
      st_nxt.boost[d] = 1'b0;
      case (cfg[CDD_DRV_FMT_LSB +: 3])
        CDD_FMT_HSTL: begin
          st_nxt.p[d]    = clk;
          st_nxt.n[d]    = ~clk;
          st_nxt.poe[d]  = en;
          st_nxt.noe[d]  = en;
          st_nxt.hstl[d] = en;
        end
        CDD_FMT_LVDS: begin
          st_nxt.p[d]     = clk;
          st_nxt.n[d]     = ~clk;
          st_nxt.poe[d]   = en;
          st_nxt.noe[d]   = en;
          st_nxt.lvds[d]  = en;
          st_nxt.boost[d] = en && cfg[CDD_DRV_BST_BIT];
        end
        CDD_FMT_CMOS, CDD_FMT_CMOS_P, CDD_FMT_CMOS_N: begin
          st_nxt.p[d]   = clk ^ pol[1];
          st_nxt.n[d]   = clk ^ ~(pol[1] ^ pol[0]);
          st_nxt.poe[d] = en && (cfg[CDD_DRV_FMT_LSB +: 3] != CDD_FMT_CMOS_N);
          st_nxt.noe[d] = en && (cfg[CDD_DRV_FMT_LSB +: 3] != CDD_FMT_CMOS_P);
        end
        // Power-down and the reserved codes leave both legs undriven
        default: begin
          st_nxt.p[d] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      st_r <= '0;
      for (int s = 0; s < CDD_NREG; s++) begin
        st_r.regs[s] <= cdd_rstval(s);
      end
      st_r.mode <= CDD_RST_MODE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_WB_ACK    = st_r.ack;
  assign O_WB_DAT    = st_r.rdat;
  assign O_DRV_P     = st_r.p;
  assign O_DRV_N     = st_r.n;
  assign O_DRV_P_OE  = st_r.poe;
  assign O_DRV_N_OE  = st_r.noe;
  assign O_DRV_HSTL  = st_r.hstl;
  assign O_DRV_LVDS  = st_r.lvds;
  assign O_DRV_BOOST = st_r.boost;
  assign O_SYNC      = st_r.sync;

endmodule
`default_nettype wire

// ### hw/cdd_top_dummy_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
